// ===== logic/dual_watchdog_system.sv
// Windowed and independent watchdog pair raising a device reset request
// =====================================================================
// Summary of operation
// RL1: Either watchdog starts from a software command, and the independent one also from its option strap.
// RL2: Once a watchdog runs, no software action stops it; only arst_n returns it to idle.
// RL3: The windowed counter must be refreshed before it drops below 0x40, else a reset is requested.
// RL4: A windowed refresh made while the counter is still above the window value still reloads the counter but requests a reset.
// RL5: The independent counter advances on edges of the 128 kHz low-speed RC clock, not on the main clock tick.
// RL6: With the option strap set the independent watchdog runs from power-on and requests a reset at end of count.
// RL7: Writing the refresh key while the independent watchdog runs reloads its counter with the programmed reload value.
`include "dual_watchdog_params.svh"

module dual_watchdog_system (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Low-speed clock and option strap pins
    input wire logic low_speed_rc_clock,
    input wire logic hw_watchdog_option,
    // Windowed watchdog software port
    input wire logic wwdg_control_write,
    input wire logic wwdg_enable,
    input wire logic [6:0] wwdg_count_value,
    input wire logic wwdg_window_write,
    input wire logic [6:0] wwdg_window_value,
    // Independent watchdog software port
    input wire logic iwdg_key_write,
    input wire logic [7:0] iwdg_key_value,
    input wire logic iwdg_reload_write,
    input wire logic [7:0] iwdg_reload_value,
    // Status and reset request
    output logic wwdg_running,
    output logic [6:0] wwdg_counter,
    output logic iwdg_running,
    output logic [7:0] iwdg_counter,
    output logic wwdg_fault,
    output logic iwdg_fault,
    output logic reset_request
);

    // =================================================================
    // State and its next value
    dual_watchdog_pkg::wdg_state_t state;
    dual_watchdog_pkg::wdg_state_t next_state;

    // =================================================================
    // Decoded strobes and ticks
    logic lsi_edge;
    logic wwdg_tick;
    logic iwdg_tick;
    logic wwdg_trip;
    logic iwdg_trip;
    logic [6:0] wwdg_dec;
    logic wwdg_refresh;
    logic wwdg_too_early;
    logic wwdg_too_late;
    logic wwdg_underflow;
    logic key_start;
    logic key_service;
    logic iwdg_expired;

    // =================================================================
    // Next-state logic
    always_comb begin
        next_state = state;
        wwdg_trip = 1'b0;
        iwdg_trip = 1'b0;
        iwdg_tick = 1'b0;

        // =============================================================
        // Two-flop synchronisers for the pins
        next_state.lsi_meta = low_speed_rc_clock;
        next_state.lsi_sync = state.lsi_meta;
        next_state.lsi_prev = state.lsi_sync;
        next_state.opt_meta = hw_watchdog_option;
        next_state.opt_sync = state.opt_meta;
        lsi_edge = state.lsi_sync & ~state.lsi_prev;

        // =============================================================
        // Software strobe decode
        wwdg_refresh = state.wwdg_active & wwdg_control_write;
        wwdg_too_early = state.wwdg_count > state.wwdg_window;
        wwdg_too_late = ~wwdg_count_value[`WWDG_EXPIRE_BIT];
        key_start = iwdg_key_write & (iwdg_key_value == `IWDG_KEY_ENABLE);
        key_service = iwdg_key_write & (iwdg_key_value == `IWDG_KEY_REFRESH);

        // =============================================================
        // Windowed watchdog prescaler
        wwdg_tick = (state.wwdg_prescale == (`WWDG_TICK_CYCLES - 12'h001));
        if (wwdg_tick) begin
            next_state.wwdg_prescale = 12'h000;
        end else begin
            next_state.wwdg_prescale = state.wwdg_prescale + 12'h001;
        end
        wwdg_dec = state.wwdg_count - 7'h01;
        wwdg_underflow = state.wwdg_count[`WWDG_EXPIRE_BIT] & ~wwdg_dec[`WWDG_EXPIRE_BIT];

        // =============================================================
        // Windowed watchdog window value
        if (wwdg_window_write) begin
            next_state.wwdg_window = wwdg_window_value;
        end

        // =============================================================
        // Windowed watchdog counter
        if (wwdg_refresh) begin // RL2
            // Enable bit is ignored here: a running watchdog stays on
            if (wwdg_too_early) begin
                wwdg_trip = 1'b1; // RL4
            end
            if (wwdg_too_late) begin
                wwdg_trip = 1'b1; // RL3
            end
            next_state.wwdg_count = wwdg_count_value; // RL3
        end else if (state.wwdg_active) begin
            if (wwdg_tick) begin
                next_state.wwdg_count = wwdg_dec;
                if (wwdg_underflow) begin
                    wwdg_trip = 1'b1; // RL3
                end
            end
        end else if (wwdg_control_write) begin
            next_state.wwdg_count = wwdg_count_value;
            next_state.wwdg_active = wwdg_enable; // RL1
            next_state.wwdg_prescale = 12'h000;
        end

        // =============================================================
        // Option strap start once the synchronised pin is valid
        if (!state.strap_taken && state.opt_sync && !state.iwdg_active) begin
            next_state.strap_taken = 1'b1;
            next_state.iwdg_active = 1'b1; // RL6
            next_state.iwdg_count = state.iwdg_reload;
            next_state.iwdg_prescale = 3'h0;
        end

        // =============================================================
        // Independent watchdog reload value
        if (iwdg_reload_write) begin
            next_state.iwdg_reload = iwdg_reload_value;
        end

        // =============================================================
        // Independent watchdog counts low-speed clock edges
        if (state.iwdg_active && lsi_edge) begin // RL5
            if (state.iwdg_prescale == (`IWDG_TICK_DIV - 3'h1)) begin
                next_state.iwdg_prescale = 3'h0;
                iwdg_tick = 1'b1;
            end else begin
                next_state.iwdg_prescale = state.iwdg_prescale + 3'h1;
            end
        end
        iwdg_expired = (state.iwdg_count == 8'h00);

        // =============================================================
        // Independent watchdog software start
        if (key_start) begin
            next_state.iwdg_active = 1'b1; // RL1
            if (!state.iwdg_active) begin
                next_state.iwdg_count = state.iwdg_reload;
                next_state.iwdg_prescale = 3'h0;
            end
        end

        // =============================================================
        // Independent watchdog service and end of count
        if (state.iwdg_active) begin
            if (key_service) begin
                next_state.iwdg_count = state.iwdg_reload; // RL7
                next_state.iwdg_prescale = 3'h0; // RL7
            end else if (iwdg_tick) begin
                if (iwdg_expired) begin
                    iwdg_trip = 1'b1; // RL6
                    next_state.iwdg_count = state.iwdg_reload;
                end else begin
                    next_state.iwdg_count = state.iwdg_count - 8'h01;
                end
            end
        end

        // =============================================================
        // Registered fault pulses
        next_state.wwdg_fault = wwdg_trip;
        next_state.iwdg_fault = iwdg_trip;
        next_state.reset_request = wwdg_trip | iwdg_trip;
    end

    // =================================================================
    // State register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state.lsi_meta <= 1'b0;
            state.lsi_sync <= 1'b0;
            state.lsi_prev <= 1'b0;
            state.opt_meta <= 1'b0;
            state.opt_sync <= 1'b0;
            state.strap_taken <= 1'b0;
            state.wwdg_active <= 1'b0; // RL2
            state.wwdg_count <= `WWDG_COUNT_RESET;
            state.wwdg_window <= `WWDG_WINDOW_RESET;
            state.wwdg_prescale <= 12'h000;
            state.iwdg_active <= 1'b0; // RL2
            state.iwdg_count <= `IWDG_RELOAD_RESET;
            state.iwdg_reload <= `IWDG_RELOAD_RESET;
            state.iwdg_prescale <= 3'h0;
            state.wwdg_fault <= 1'b0;
            state.iwdg_fault <= 1'b0;
            state.reset_request <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // =================================================================
    // Outputs straight from the state register
    assign wwdg_running = state.wwdg_active;
    assign wwdg_counter = state.wwdg_count;
    assign iwdg_running = state.iwdg_active;
    assign iwdg_counter = state.iwdg_count;
    assign wwdg_fault = state.wwdg_fault;
    assign iwdg_fault = state.iwdg_fault;
    assign reset_request = state.reset_request;

endmodule : dual_watchdog_system

// ===== logic/dual_watchdog_params.svh
// Offsets-free constants: reset values, key codes and tick counts of the watchdog pair
`ifndef DUAL_WATCHDOG_PARAMS_SVH
`define DUAL_WATCHDOG_PARAMS_SVH

// =====================================================================
// Windowed watchdog
`define WWDG_COUNT_RESET 7'h7F
`define WWDG_WINDOW_RESET 7'h7F
`define WWDG_EXPIRE_BIT 6
`define WWDG_TICK_CYCLES 12'h040

// =====================================================================
// Independent watchdog
`define IWDG_KEY_ENABLE 8'hCC
`define IWDG_KEY_REFRESH 8'hAA
`define IWDG_RELOAD_RESET 8'hFF
`define IWDG_TICK_DIV 3'h4

`endif

// ===== logic/dual_watchdog_pkg.sv
// Types shared by the dual watchdog design
package dual_watchdog_pkg;

    // =================================================================
    // Whole state of the watchdog pair
    typedef struct packed {
        logic lsi_meta;
        logic lsi_sync;
        logic lsi_prev;
        logic opt_meta;
        logic opt_sync;
        logic strap_taken;
        logic wwdg_active;
        logic [6:0] wwdg_count;
        logic [6:0] wwdg_window;
        logic [11:0] wwdg_prescale;
        logic iwdg_active;
        logic [7:0] iwdg_count;
        logic [7:0] iwdg_reload;
        logic [2:0] iwdg_prescale;
        logic wwdg_fault;
        logic iwdg_fault;
        logic reset_request;
    } wdg_state_t;

endpackage : dual_watchdog_pkg

// ===== dv/low_speed_clock_model.sv
// Free-running low-speed RC clock model
module low_speed_clock_model (
    // Clock out
    output logic low_speed_rc_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        low_speed_rc_clock = 1'b0;
        forever #3906.3 low_speed_rc_clock = ~low_speed_rc_clock;
    end
endmodule : low_speed_clock_model

// ===== dv/dual_watchdog_system_assertions.sv
// Port checks of the watchdog pair
`include "dual_watchdog_params.svh"
module dual_watchdog_checker (
    // Clock and inputs
    input wire logic clock,
    input wire logic arst_n,
    input wire logic low_speed_rc_clock,
    input wire logic hw_watchdog_option,
    input wire logic wwdg_control_write,
    input wire logic wwdg_enable,
    input wire logic [6:0] wwdg_count_value,
    input wire logic iwdg_key_write,
    input wire logic [7:0] iwdg_key_value,
    // Outputs
    input wire logic wwdg_running,
    input wire logic [6:0] wwdg_counter,
    input wire logic iwdg_running,
    input wire logic [7:0] iwdg_counter,
    input wire logic wwdg_fault,
    input wire logic iwdg_fault,
    input wire logic reset_request
);
    // =================================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_wstart;
        wwdg_control_write && wwdg_enable && !wwdg_running;
    endsequence
    sequence s_quiet;
        (!iwdg_key_write && $stable(low_speed_rc_clock)) [*8];
    endsequence
    chk_wwdg_start: assert property (s_wstart |=> wwdg_running && wwdg_counter == $past(wwdg_count_value))
        else $error("windowed start");
    chk_iwdg_start: assert property (iwdg_key_write && iwdg_key_value == `IWDG_KEY_ENABLE |=> iwdg_running)
        else $error("independent start");
    chk_wwdg_hold: assert property (wwdg_running |=> wwdg_running)
        else $error("windowed stopped");
    chk_iwdg_hold: assert property (iwdg_running |=> iwdg_running)
        else $error("independent stopped");
    chk_wwdg_expiry: assert property (wwdg_running && $fell(wwdg_counter[6]) |-> wwdg_fault)
        else $error("windowed expiry");
    chk_reset_merge: assert property (reset_request == (wwdg_fault || iwdg_fault))
        else $error("reset merge");
    chk_iwdg_quiet: assert property (s_quiet |-> $stable(iwdg_counter))
        else $error("counter moved");
    chk_iwdg_trip: assert property (iwdg_fault |-> iwdg_running && $past(iwdg_counter) == 8'h00)
        else $error("independent trip");
    chk_strap_start: assert property ($past(arst_n, 3) && $past(hw_watchdog_option, 3) |-> iwdg_running)
        else $error("strap start");
endmodule : dual_watchdog_checker
bind dual_watchdog_system dual_watchdog_checker i_chk (.clock, .arst_n, .low_speed_rc_clock, .hw_watchdog_option,
    .wwdg_control_write,
    .wwdg_enable, .wwdg_count_value, .iwdg_key_write, .iwdg_key_value, .wwdg_running, .wwdg_counter,
    .iwdg_running, .iwdg_counter, .wwdg_fault, .iwdg_fault, .reset_request);

// ===== dv/dual_watchdog_system_test.sv
// Self-checking bench of the watchdog pair
`include "dual_watchdog_params.svh"
module dual_watchdog_system_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, arst_n, low_speed_rc_clock, hw_watchdog_option, wwdg_control_write, wwdg_enable, wwdg_window_write;
    logic iwdg_key_write, iwdg_reload_write, wwdg_running, iwdg_running, wwdg_fault, iwdg_fault, reset_request;
    logic [6:0] wwdg_count_value, wwdg_window_value, wwdg_counter;
    logic [7:0] iwdg_key_value, iwdg_reload_value, iwdg_counter;
    int n_mismatch = 0;
    int tests_run = 0;
    // =================================================================
    // Instances and tasks
    low_speed_clock_model i_lsc (.low_speed_rc_clock);
    dual_watchdog_system i_dut (.clock, .arst_n, .low_speed_rc_clock, .hw_watchdog_option, .wwdg_control_write,
        .wwdg_enable, .wwdg_count_value, .wwdg_window_write, .wwdg_window_value, .iwdg_key_write, .iwdg_key_value,
        .iwdg_reload_write, .iwdg_reload_value, .wwdg_running, .wwdg_counter, .iwdg_running, .iwdg_counter,
        .wwdg_fault, .iwdg_fault, .reset_request);
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wait_on(input int lim, input logic [7:0] cnt);
        for (int i = 0; i < lim && reset_request !== 1'b1 && iwdg_counter !== cnt; i++) begin
            @(posedge clock);
            #1;
        end
    endtask : wait_on
    task automatic do_reset;
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
    endtask : do_reset
    task automatic wwdg_timeout;
        do_reset();
        @(posedge clock);
        {wwdg_control_write, wwdg_enable, wwdg_count_value} <= {2'b11, 7'h41};
        @(posedge clock);
        wwdg_enable <= 1'b0;
        #1;
        cmp(wwdg_counter, 8'h41);
        @(posedge clock);
        wwdg_control_write <= 1'b0;
        wait_on(200, 8'hFE);
        cmp({wwdg_fault, wwdg_counter}, 8'hBF);
        cmp(wwdg_running, 1'b1);
    endtask : wwdg_timeout
    task automatic wwdg_early;
        do_reset();
        @(posedge clock);
        {wwdg_window_write, wwdg_window_value} <= {1'b1, 7'h50};
        @(posedge clock);
        wwdg_window_write <= 1'b0;
        {wwdg_control_write, wwdg_enable, wwdg_count_value} <= {2'b11, 7'h7F};
        repeat (2) @(posedge clock);
        wwdg_control_write <= 1'b0;
        #1;
        cmp({wwdg_fault, reset_request}, 8'h03);
    endtask : wwdg_early
    task automatic iwdg_cycle;
        do_reset();
        @(posedge clock);
        {iwdg_reload_write, iwdg_reload_value, iwdg_key_write, iwdg_key_value} <= {1'b1, 8'h02, 1'b1, 8'h00};
        @(posedge clock);
        {iwdg_reload_write, iwdg_key_value} <= {1'b0, `IWDG_KEY_REFRESH};
        @(posedge clock);
        iwdg_key_value <= `IWDG_KEY_ENABLE;
        #1;
        cmp(iwdg_running, 1'b0);
        @(posedge clock);
        iwdg_key_write <= 1'b0;
        #1;
        cmp({iwdg_running, iwdg_counter[6:0]}, 8'h82);
        wait_on(2000, 8'h01);
        @(posedge clock);
        {iwdg_key_write, iwdg_key_value} <= {1'b1, `IWDG_KEY_REFRESH};
        @(posedge clock);
        iwdg_key_write <= 1'b0;
        #1;
        cmp(iwdg_counter, 8'h02);
        wait_on(5000, 8'hFE);
        cmp({iwdg_fault, wwdg_fault, iwdg_running}, 8'h05);
    endtask : iwdg_cycle
    task automatic iwdg_strap;
        @(posedge clock);
        hw_watchdog_option <= 1'b1;
        do_reset();
        repeat (4) @(posedge clock);
        #1;
        cmp({iwdg_running, iwdg_counter[6:0]}, 8'hFF);
    endtask : iwdg_strap
    task automatic print_verdict;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        {arst_n, hw_watchdog_option, wwdg_control_write, wwdg_enable, wwdg_window_write} = 5'h00;
        {iwdg_key_write, iwdg_reload_write, wwdg_count_value, wwdg_window_value} = 16'h0000;
        {iwdg_key_value, iwdg_reload_value} = 16'h0000;
        wwdg_timeout();
        wwdg_early();
        iwdg_cycle();
        iwdg_strap();
        print_verdict();
    end
    initial begin
        #500000;
        n_mismatch++;
        print_verdict();
    end
endmodule : dual_watchdog_system_test
